// ==== logic/tcc_pkg.sv ====
/*
  Package for the 16-bit timer capture/compare block: register offsets,
  field positions, reset values, timing constants and waveform modes.
  Assumes a byte-wide register port on the system clock.
*/
`default_nettype none
package tcc_pkg;
  // register offsets (byte-wide plain port)
  localparam logic [3:0] TCC_CAP_LO_OFS  = 4'h0;
  localparam logic [3:0] TCC_CAP_HI_OFS  = 4'h1;
  localparam logic [3:0] TCC_CMPA_LO_OFS = 4'h2;
  localparam logic [3:0] TCC_CMPA_HI_OFS = 4'h3;
  localparam logic [3:0] TCC_CMPB_LO_OFS = 4'h4;
  localparam logic [3:0] TCC_CMPB_HI_OFS = 4'h5;
  localparam logic [3:0] TCC_CTRLA_OFS   = 4'h6;
  localparam logic [3:0] TCC_CTRLB_OFS   = 4'h7;
  localparam logic [3:0] TCC_MASK_OFS    = 4'h8;
  localparam logic [3:0] TCC_FLAG_OFS    = 4'h9;
  localparam logic [3:0] TCC_CMPSTAT_OFS = 4'hA;
  // control A: [1:0] waveform mode low, [5:4] out mode B, [7:6] out mode A
  localparam int TCC_WGM_LO_POS  = 0;
  localparam int TCC_COMB_POS    = 4;
  localparam int TCC_COMA_POS    = 6;
  // control B: [4:3] waveform mode high, [6] edge select, [7] filter enable
  localparam int TCC_WGM_HI_POS  = 3;
  localparam int TCC_EDGE_POS    = 6;
  localparam int TCC_FILT_POS    = 7;
  // comparator ctrl/status: [2] comparator capture select
  localparam int TCC_ACSEL_POS   = 2;
  // mask and flag: [0] capture, [1] compare A, [2] compare B
  localparam int TCC_CAP_POS     = 0;
  localparam int TCC_CMPA_POS    = 1;
  localparam int TCC_CMPB_POS    = 2;
  localparam logic [7:0]  TCC_CTRL_RST  = 8'h00;
  localparam logic [15:0] TCC_WORD_RST  = 16'h0000;
  // filter depth: four equal samples, four extra system clocks
  localparam int TCC_FILT_SAMPLES = 4;
  // waveform modes that matter to this block
  localparam logic [3:0] TCC_WGM_NORMAL   = 4'h0;
  localparam logic [3:0] TCC_WGM_CTC_OCR  = 4'h4;
  localparam logic [3:0] TCC_WGM_PFC_ICR  = 4'h8;
  localparam logic [3:0] TCC_WGM_PC_ICR   = 4'hA;
  localparam logic [3:0] TCC_WGM_CTC_ICR  = 4'hC;
  localparam logic [3:0] TCC_WGM_RSVD     = 4'hD;
  localparam logic [3:0] TCC_WGM_FAST_ICR = 4'hE;
  localparam logic [3:0] TCC_WGM_PFC_OCR  = 4'h9;
  localparam logic [3:0] TCC_WGM_PC_OCR   = 4'hB;
  localparam logic [3:0] TCC_WGM_FAST_OCR = 4'hF;
  // phase-correct modes reload at TOP? no: at BOTTOM for pfc, TOP for others
  typedef enum logic [1:0] {
    TCC_IDLE_T  = 2'b00,
    TCC_ARMED_T = 2'b01
  } tcc_cap_state_t;
endpackage
`default_nettype wire

// ==== logic/tcc_filter.sv ====
/*
  Capture input conditioner: two-stage synchroniser and an optional
  four-sample majority-free noise filter.  Assumes a raw asynchronous input.
*/
`default_nettype none
module tcc_filter
  import tcc_pkg::*;
(
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic clkEn,
  input  wire logic rawIn,
  input  wire logic filtEn,
  output logic      condOut
);
  logic                        sync1Reg;
  logic                        sync2Reg;
  logic [TCC_FILT_SAMPLES-2:0] histReg;
  logic                        filtReg;
  logic                        allHigh;
  logic                        allLow;

  // live sample plus three stored ones: a fourth stored stage would cost a fifth clock
  assign allHigh = &{histReg, sync2Reg};
  assign allLow  = ~|{histReg, sync2Reg};
  assign condOut = filtEn ? filtReg : sync2Reg;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sync1Reg <= 1'b0;
      sync2Reg <= 1'b0;
      histReg  <= '0;
      filtReg  <= 1'b0;
    end
    else if (clkEn)
    begin
      sync1Reg <= rawIn;
      sync2Reg <= sync1Reg;
      // samples on every system clock, prescaler never involved
      histReg  <= {histReg[TCC_FILT_SAMPLES-3:0], sync2Reg};
      if (allHigh)
        filtReg <= 1'b1; // output moves only on four equal samples
      else if (allLow)
        filtReg <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== logic/tcc_capture_compare.sv ====
/*
  Input capture and output compare units of a 16-bit timer.
  Assumes the counter, prescaler tick, TOP/BOTTOM indications and
  waveform generator live outside and use the match pulses given here.
*/
// Notes on behaviour
// - trigger is pin, or comparator when selected
// - trigger source switch may set capture flag
// - filter adds four system clocks of delay
// - capture disabled only in capture-TOP modes
// - software driving pin port can capture
// - filter output changes on four equal samples
// - filter enable bit, samples undivided clock
// - each capture overwrites capture register
// - compare flag set one timer tick after match
// - enabled compare flag requests irq, auto-cleared
// - writing one clears flag, zero ignored
// - match, modes and TOP sources go to waveform
// - compare A may define counter TOP
// - double-buffered in PWM, direct otherwise
// - buffered value loads at TOP or BOTTOM
// - capture copies counter, sets flag same clock
// - shared upper-byte staging for 16-bit access
// - enabled capture flag requests irq, auto-cleared
`default_nettype none
module tcc_capture_compare
  import tcc_pkg::*;
#(
  parameter bit HAS_COMPARATOR = 1'b1
)
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  input  wire logic [3:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdata,
  input  wire logic        capture_input_pin,
  input  wire logic        comparator_output,
  input  wire logic [15:0] counter_value,
  input  wire logic        timerTick,
  input  wire logic        counterAtTop,
  input  wire logic        counterAtBottom,
  input  wire logic        capIrqAck,
  input  wire logic        cmpAIrqAck,
  input  wire logic        cmpBIrqAck,
  output logic             capIrqReq,
  output logic             cmpAIrqReq,
  output logic             cmpBIrqReq,
  output logic             cmpAMatch,
  output logic             cmpBMatch,
  output logic      [3:0]  waveform_mode_field,
  output logic      [1:0]  compareModeA,
  output logic      [1:0]  compareModeB,
  output logic      [15:0] topFromA,
  output logic      [15:0] topFromCapture,
  output logic             topIsCompareA
);
  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  ctrlA_reg;
  logic [7:0]  timer_control_b_reg;
  logic [7:0]  comparator_ctrl_status_reg;
  logic [7:0]  maskReg;
  logic [15:0] capture_value_reg;
  logic [15:0] compareActA_reg;
  logic [15:0] compareActB_reg;
  logic [15:0] compareBufA_reg;
  logic [15:0] compareBufB_reg;
  logic [7:0]  stagingReg;
  logic        capture_flag_reg;
  logic        compare_flagA_reg;
  logic        compare_flagB_reg;
  logic        matchA_reg;
  logic        matchB_reg;
  logic        prevCond_reg;
  logic [7:0]  rdata_next;
  logic [7:0]  rdataReg;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  logic wrCapLo;
  logic wrCapHi;
  logic wrCmpALo;
  logic wrCmpAHi;
  logic wrCmpBLo;
  logic wrCmpBHi;
  logic wrCtrlA;
  logic wrCtrlB;
  logic wrMask;
  logic wrFlag;
  logic wrCmpStat;
  logic rdCapLo;

  assign wrCapLo   = regWr && regAddr == TCC_CAP_LO_OFS;
  assign wrCapHi   = regWr && regAddr == TCC_CAP_HI_OFS;
  assign wrCmpALo  = regWr && regAddr == TCC_CMPA_LO_OFS;
  assign wrCmpAHi  = regWr && regAddr == TCC_CMPA_HI_OFS;
  assign wrCmpBLo  = regWr && regAddr == TCC_CMPB_LO_OFS;
  assign wrCmpBHi  = regWr && regAddr == TCC_CMPB_HI_OFS;
  assign wrCtrlA   = regWr && regAddr == TCC_CTRLA_OFS;
  assign wrCtrlB   = regWr && regAddr == TCC_CTRLB_OFS;
  assign wrMask    = regWr && regAddr == TCC_MASK_OFS;
  assign wrFlag    = regWr && regAddr == TCC_FLAG_OFS;
  assign wrCmpStat = regWr && regAddr == TCC_CMPSTAT_OFS;
  assign rdCapLo   = regRd && regAddr == TCC_CAP_LO_OFS;

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  logic [3:0] wgm;
  logic       capTopMode;
  logic       ocrTopMode;
  logic       pwmMode;
  logic       reloadAtBottom;
  logic       reloadNow;

  assign wgm = {timer_control_b_reg[TCC_WGM_HI_POS+1:TCC_WGM_HI_POS],
                ctrlA_reg[TCC_WGM_LO_POS+1:TCC_WGM_LO_POS]};
  assign capTopMode = wgm == TCC_WGM_PFC_ICR || wgm == TCC_WGM_PC_ICR
                   || wgm == TCC_WGM_CTC_ICR || wgm == TCC_WGM_FAST_ICR;
  assign ocrTopMode = wgm == TCC_WGM_CTC_OCR || wgm == TCC_WGM_PFC_OCR
                   || wgm == TCC_WGM_PC_OCR || wgm == TCC_WGM_FAST_OCR;
  // everything except normal, the two clear-on-match modes and reserved is pwm
  assign pwmMode = !(wgm == TCC_WGM_NORMAL || wgm == TCC_WGM_CTC_OCR
                  || wgm == TCC_WGM_CTC_ICR || wgm == TCC_WGM_RSVD);
  // phase-and-frequency-correct modes reload at bottom, others at top
  assign reloadAtBottom = wgm == TCC_WGM_PFC_ICR || wgm == TCC_WGM_PFC_OCR;
  assign reloadNow = pwmMode && timerTick
                  && (reloadAtBottom ? counterAtBottom : counterAtTop);

  ////////////////////////////////////////////////////////////////////////////
  // capture trigger path
  logic compSel;
  logic rawTrig;
  logic condIn;
  logic edgeRise;
  logic edgeFall;
  logic capEvent;

  assign compSel = HAS_COMPARATOR
                && comparator_ctrl_status_reg[TCC_ACSEL_POS];
  // pin is sensed whoever drives it, so port writes capture too
  assign rawTrig = compSel ? comparator_output : capture_input_pin;

  tcc_filter filter_u (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .clkEn   (clkEn),
    .rawIn   (rawTrig),
    .filtEn  (timer_control_b_reg[TCC_FILT_POS]),
    .condOut (condIn)
  );

  // a source switch changes condIn and may look like an edge
  assign edgeRise = condIn && !prevCond_reg;
  assign edgeFall = !condIn && prevCond_reg;
  assign capEvent = !capTopMode
                 && (timer_control_b_reg[TCC_EDGE_POS] ? edgeRise : edgeFall);

  ////////////////////////////////////////////////////////////////////////////
  // compare matches
  logic eqA;
  logic eqB;
  assign eqA = counter_value == compareActA_reg;
  assign eqB = counter_value == compareActB_reg;

  ////////////////////////////////////////////////////////////////////////////
  // flags: hardware set wins over clears
  logic capClr;
  logic cmpAClr;
  logic cmpBClr;
  assign capClr  = (wrFlag && regWdata[TCC_CAP_POS]) || capIrqAck;
  assign cmpAClr = (wrFlag && regWdata[TCC_CMPA_POS]) || cmpAIrqAck;
  assign cmpBClr = (wrFlag && regWdata[TCC_CMPB_POS]) || cmpBIrqAck;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      capture_flag_reg  <= 1'b0;
      compare_flagA_reg <= 1'b0;
      compare_flagB_reg <= 1'b0;
      matchA_reg        <= 1'b0;
      matchB_reg        <= 1'b0;
      prevCond_reg      <= 1'b0;
      capture_value_reg <= TCC_WORD_RST;
    end
    else if (clkEn)
    begin
      prevCond_reg <= condIn;
      if (capEvent)
        capture_flag_reg <= 1'b1;
      else if (capClr)
        capture_flag_reg <= 1'b0;
      if (capEvent)
        capture_value_reg <= counter_value; // always overwrites
      else if (wrCapLo && capTopMode)
        capture_value_reg <= {stagingReg, regWdata};
      if (timerTick)
      begin
        matchA_reg <= eqA;
        matchB_reg <= eqB;
      end
      if (timerTick && matchA_reg)
        compare_flagA_reg <= 1'b1; // next tick after the match
      else if (cmpAClr)
        compare_flagA_reg <= 1'b0;
      if (timerTick && matchB_reg)
        compare_flagB_reg <= 1'b1;
      else if (cmpBClr)
        compare_flagB_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers and 16-bit writes through the staging byte
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ctrlA_reg                  <= TCC_CTRL_RST;
      timer_control_b_reg        <= TCC_CTRL_RST;
      comparator_ctrl_status_reg <= TCC_CTRL_RST;
      maskReg                    <= TCC_CTRL_RST;
      stagingReg                 <= TCC_CTRL_RST;
      compareActA_reg            <= TCC_WORD_RST;
      compareActB_reg            <= TCC_WORD_RST;
      compareBufA_reg            <= TCC_WORD_RST;
      compareBufB_reg            <= TCC_WORD_RST;
    end
    else if (clkEn)
    begin
      if (wrCtrlA)
        ctrlA_reg <= regWdata;
      if (wrCtrlB)
        timer_control_b_reg <= regWdata;
      if (wrCmpStat)
        comparator_ctrl_status_reg <= regWdata;
      if (wrMask)
        maskReg <= regWdata;
      if (wrCapHi || wrCmpAHi || wrCmpBHi)
        stagingReg <= regWdata;
      else if (rdCapLo)
        stagingReg <= capture_value_reg[15:8];
      if (wrCmpALo)
        compareBufA_reg <= {stagingReg, regWdata};
      if (wrCmpBLo)
        compareBufB_reg <= {stagingReg, regWdata};
      if (wrCmpALo && !pwmMode)
        compareActA_reg <= {stagingReg, regWdata}; // direct write
      else if (reloadNow)
        compareActA_reg <= compareBufA_reg;
      if (wrCmpBLo && !pwmMode)
        compareActB_reg <= {stagingReg, regWdata};
      else if (reloadNow)
        compareActB_reg <= compareBufB_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read back, one cycle after the strobe
  logic [7:0] flagByte;
  logic [7:0] cmpARd;
  logic [7:0] cmpBRd;
  assign flagByte = {5'h0, compare_flagB_reg, compare_flagA_reg, capture_flag_reg};

  always_comb
  begin
    cmpARd = pwmMode ? compareBufA_reg[7:0] : compareActA_reg[7:0];
    cmpBRd = pwmMode ? compareBufB_reg[7:0] : compareActB_reg[7:0];
    case (regAddr)
      TCC_CAP_LO_OFS:  rdata_next = capture_value_reg[7:0];
      TCC_CAP_HI_OFS:  rdata_next = stagingReg;
      TCC_CMPA_LO_OFS: rdata_next = cmpARd;
      TCC_CMPA_HI_OFS: rdata_next = pwmMode ? compareBufA_reg[15:8] : compareActA_reg[15:8];
      TCC_CMPB_LO_OFS: rdata_next = cmpBRd;
      TCC_CMPB_HI_OFS: rdata_next = pwmMode ? compareBufB_reg[15:8] : compareActB_reg[15:8];
      TCC_CTRLA_OFS:   rdata_next = ctrlA_reg;
      TCC_CTRLB_OFS:   rdata_next = timer_control_b_reg;
      TCC_MASK_OFS:    rdata_next = maskReg;
      TCC_FLAG_OFS:    rdata_next = flagByte;
      TCC_CMPSTAT_OFS: rdata_next = comparator_ctrl_status_reg;
      default:         rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rdataReg <= 8'h00;
    else if (clkEn)
      rdataReg <= regRd ? rdata_next : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign regRdata            = rdataReg;
  assign capIrqReq  = capture_flag_reg && maskReg[TCC_CAP_POS];
  assign cmpAIrqReq = compare_flagA_reg && maskReg[TCC_CMPA_POS];
  assign cmpBIrqReq = compare_flagB_reg && maskReg[TCC_CMPB_POS];
  assign cmpAMatch           = matchA_reg;
  assign cmpBMatch           = matchB_reg;
  assign waveform_mode_field = wgm;
  assign compareModeA        = ctrlA_reg[TCC_COMA_POS+1:TCC_COMA_POS];
  assign compareModeB        = ctrlA_reg[TCC_COMB_POS+1:TCC_COMB_POS];
  assign topFromA            = compareActA_reg;
  assign topIsCompareA       = ocrTopMode;
  assign topFromCapture      = capture_value_reg;
endmodule
`default_nettype wire

// ==== dv/tcc_capture_compare_assertions.sv ====
/*
  Checker for the timer capture/compare block, bound to its top module.
  Assumes clkEn is held high, so every clock edge is an active one.
*/
`default_nettype none
module tcc_capture_compare_assertions
  import tcc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic [3:0]  regAddr,
  input wire logic [7:0]  regWdata,
  input wire logic        regWr,
  input wire logic        capture_input_pin,
  input wire logic        timerTick,
  input wire logic        capIrqAck,
  input wire logic        cmpAIrqAck,
  input wire logic        capIrqReq,
  input wire logic        cmpAIrqReq,
  input wire logic        cmpBIrqReq,
  input wire logic        cmpAMatch,
  input wire logic [3:0]  waveform_mode_field,
  input wire logic [1:0]  compareModeA,
  input wire logic [15:0] topFromA,
  input wire logic        topIsCompareA
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire logic pwmMode;
  assign pwmMode = !(waveform_mode_field inside {4'h0, 4'h4, 4'hC, 4'hD});
  //////////////////////////////////////////////////////////////////////////////
  a_ctrlb_mode: assert property (regWr && regAddr == TCC_CTRLB_OFS |=>
    waveform_mode_field[3:2] == $past(regWdata[4:3])) else $error("mode high bits lost");
  a_ctrla_fields: assert property (regWr && regAddr == TCC_CTRLA_OFS |=>
    compareModeA == $past(regWdata[7:6]) && waveform_mode_field[1:0] == $past(regWdata[1:0]))
    else $error("control A fields lost");
  a_match_hold: assert property (!timerTick |=> $stable(cmpAMatch))
    else $error("match moved without a tick");
  a_top_source: assert property (topIsCompareA |->
    waveform_mode_field inside {4'h4, 4'h9, 4'hB, 4'hF}) else $error("bad top source");
  a_cmp_direct: assert property (regWr && regAddr == TCC_CMPA_LO_OFS && !pwmMode |=>
    topFromA[7:0] == $past(regWdata)) else $error("direct compare write lost");
  a_cmp_buffered: assert property (!timerTick && pwmMode |=> $stable(topFromA))
    else $error("buffered compare loaded off a tick");
  a_cmp_ack: assert property (cmpAIrqAck && !timerTick |=> !cmpAIrqReq)
    else $error("compare flag kept after service");
  a_cap_ack: assert property ($stable(capture_input_pin)[*8] ##0 capIrqAck |=>
    !capIrqReq) else $error("capture flag kept after service");
  a_mask_off: assert property (regWr && regAddr == TCC_MASK_OFS && regWdata == 8'h00 |=>
    !(capIrqReq || cmpAIrqReq || cmpBIrqReq)) else $error("request with mask clear");
  c_cap_ack: cover property (capIrqAck && capIrqReq);
  c_cmp_ack: cover property (cmpAIrqAck && cmpAIrqReq);
  c_reload: cover property (pwmMode && timerTick ##1 $changed(topFromA));
endmodule
`default_nettype wire

// ==== dv/tcc_counter_model.sv ====
/*
  Model of the counter that feeds the block: counts on every second clock
  while run is high and wraps at topVal.  Assumes the bench holds topVal.
*/
`default_nettype none
module tcc_counter_model
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        run,
  input  wire logic [15:0] topVal,
  output logic      [15:0] counter_value,
  output logic             timerTick,
  output logic             counterAtTop,
  output logic             counterAtBottom
);
  timeunit 1ns;
  timeprecision 1ps;
  // top stays fixed for a whole run, so captures never see a moving top
  assign counterAtTop = counter_value == topVal;
  assign counterAtBottom = counter_value == 16'h0000;
  always @(posedge mclk)
  begin
    timerTick <= !sys_rst && run && !timerTick;
    if (sys_rst)
      counter_value <= 16'h0000;
    else if (timerTick)
      counter_value <= counterAtTop ? 16'h0000 : counter_value + 16'h0001;
  end
endmodule
`default_nettype wire

// ==== dv/tb_timer16_capture_compare_units.sv ====
/*
  Testbench for the capture/compare block: register tasks, capture, filter,
  source select and compare scenarios.  Assumes the counter model beside it.
*/
`default_nettype none
module tb_timer16_capture_compare_units
  import tcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, sys_rst, clkEn, regWr, regRd, run, capIrqAck, cmpAIrqAck, cmpBIrqAck;
  logic        capture_input_pin, comparator_output, timerTick, counterAtTop, counterAtBottom;
  logic        capIrqReq, cmpAIrqReq, cmpBIrqReq, cmpAMatch, cmpBMatch, topIsCompareA;
  logic [3:0]  regAddr, waveform_mode_field;
  logic [7:0]  regWdata, regRdata, v, w;
  logic [1:0]  compareModeA, compareModeB;
  logic [15:0] counter_value, topVal, topFromA, topFromCapture, expV;
  int          n_errors, num_checks, seed, lat0, lat1, n, m;
  tcc_capture_compare DUT (
    .mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .capture_input_pin(capture_input_pin),
    .comparator_output(comparator_output), .counter_value(counter_value),
    .timerTick(timerTick), .counterAtTop(counterAtTop), .counterAtBottom(counterAtBottom),
    .capIrqAck(capIrqAck), .cmpAIrqAck(cmpAIrqAck), .cmpBIrqAck(cmpBIrqAck),
    .capIrqReq(capIrqReq), .cmpAIrqReq(cmpAIrqReq), .cmpBIrqReq(cmpBIrqReq),
    .cmpAMatch(cmpAMatch), .cmpBMatch(cmpBMatch), .waveform_mode_field(waveform_mode_field),
    .compareModeA(compareModeA), .compareModeB(compareModeB), .topFromA(topFromA),
    .topFromCapture(topFromCapture), .topIsCompareA(topIsCompareA)
  );
  tcc_counter_model partner (
    .mclk(mclk), .sys_rst(sys_rst), .run(run), .topVal(topVal), .counter_value(counter_value),
    .timerTick(timerTick), .counterAtTop(counterAtTop), .counterAtBottom(counterAtBottom)
  );
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  // drive one input level and count clocks until the capture request shows
  task automatic edgeLat(input bit src, input logic lvl, output int k);
    @(posedge mclk);
    if (src) comparator_output <= lvl;
    else capture_input_pin <= lvl;
    k = 0;
    do
    begin
      @(posedge mclk);
      #1 k++;
    end
    while (capIrqReq !== 1'b1 && k < 40);
    if (k >= 40)
    begin
      n_errors++;
      results();
    end
  endtask
  // short excursion of the pin and back; no capture may follow
  task automatic blip();
    @(posedge mclk);
    capture_input_pin <= ~capture_input_pin;
    repeat (3) @(posedge mclk);
    capture_input_pin <= ~capture_input_pin;
    repeat (20) @(posedge mclk);
    #1;
  endtask
  task automatic freeze();
    run <= 1'b1;
    repeat (8 + ($random(seed) & 63)) @(posedge mclk);
    run <= 1'b0;
    repeat (4) @(posedge mclk);
    expV = counter_value;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    {regWr, regRd, run, capIrqAck, cmpAIrqAck, cmpBIrqAck} = '0;
    {capture_input_pin, comparator_output, regAddr, regWdata} = '0;
    seed = 29817;
    clkEn = 1'b1;
    topVal = 16'h00FF;
    sys_rst = 1'b1;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      v = $random(seed);
      w = $random(seed) & 8'h58;
      wr(TCC_CTRLB_OFS, w);
      wr(TCC_CTRLA_OFS, v);
      #1 chk(16'(compareModeA), 16'(v[7:6]));
      chk(16'(compareModeB), 16'(v[5:4]));
      chk(16'(waveform_mode_field), 16'({w[4:3], v[1:0]}));
      chk(16'(topIsCompareA), 16'({w[4:3], v[1:0]} inside {4'h4, 4'h9, 4'hB, 4'hF}));
    end
    rd(4'hF, v);
    chk(16'(v), 16'h0000);
    wr(TCC_CTRLA_OFS, 8'h00);
    wr(TCC_CTRLB_OFS, 8'h40);
    wr(TCC_MASK_OFS, 8'h07);
    freeze();
    wr(TCC_FLAG_OFS, 8'h01);
    edgeLat(0, 1'b1, lat0);
    rd(TCC_CAP_LO_OFS, v);
    rd(TCC_CAP_HI_OFS, w);
    chk({w, v}, expV);
    freeze();
    wr(TCC_CTRLB_OFS, 8'h00);
    wr(TCC_FLAG_OFS, 8'h01);
    edgeLat(0, 1'b0, lat0);
    rd(TCC_CAP_LO_OFS, v);
    rd(TCC_CAP_HI_OFS, w);
    chk({w, v}, expV);
    wr(TCC_FLAG_OFS, 8'h00);
    rd(TCC_FLAG_OFS, v);
    chk(16'(v[0]), 16'h0001);
    wr(TCC_FLAG_OFS, 8'h01);
    rd(TCC_FLAG_OFS, v);
    chk(16'(v[0]), 16'h0000);
    wr(TCC_CTRLB_OFS, 8'hC0);
    blip();
    chk(16'(capIrqReq), 16'h0000);
    edgeLat(0, 1'b1, lat1);
    chk(16'(lat1), 16'(lat0 + TCC_FILT_SAMPLES));
    repeat (10) @(posedge mclk);
    capIrqAck <= 1'b1;
    @(posedge mclk);
    capIrqAck <= 1'b0;
    #1 chk(16'(capIrqReq), 16'h0000);
    wr(TCC_CTRLB_OFS, 8'h00);
    wr(TCC_CMPSTAT_OFS, 8'h04);
    repeat (10) @(posedge mclk);
    #1 chk(16'(capIrqReq), 16'h0001);
    wr(TCC_FLAG_OFS, 8'h01);
    wr(TCC_CTRLB_OFS, 8'h40);
    blip();
    chk(16'(capIrqReq), 16'h0000);
    edgeLat(1, 1'b1, lat1);
    chk(16'(lat1), 16'(lat0));
    wr(TCC_CMPSTAT_OFS, 8'h00);
    wr(TCC_CTRLB_OFS, 8'h58);
    wr(TCC_FLAG_OFS, 8'h01);
    blip();
    chk(16'(capIrqReq), 16'h0000);
    v = $random(seed);
    w = $random(seed);
    wr(TCC_CAP_HI_OFS, w);
    wr(TCC_CAP_LO_OFS, v);
    #1 chk(topFromCapture, {w, v});
    wr(TCC_CTRLB_OFS, 8'h40);
    for (int i = 0; i < 2; i++)
    begin
      v = $random(seed);
      wr(4'(TCC_CMPA_HI_OFS + 2 * i), 8'h00);
      wr(4'(TCC_CMPA_LO_OFS + 2 * i), v);
      wr(TCC_FLAG_OFS, 8'h06);
      run <= 1'b1;
      n = 0;
      m = 0;
      do
      begin
        @(posedge mclk);
        #1 n++;
        m += int'(i ? cmpBMatch : cmpAMatch);
      end
      while ((i ? cmpBIrqReq : cmpAIrqReq) !== 1'b1 && n < 700);
      if (n >= 700) begin n_errors++; results(); end
      chk(counter_value, 16'(8'(v + 8'h02)));
      chk(16'(m), 16'h0002);
      repeat (2) @(posedge mclk);
      if (i) cmpBIrqAck <= 1'b1;
      else cmpAIrqAck <= 1'b1;
      @(posedge mclk);
      {cmpAIrqAck, cmpBIrqAck} <= 2'b00;
      run <= 1'b0;
      #1 chk(16'(i ? cmpBIrqReq : cmpAIrqReq), 16'h0000);
    end
    expV = topFromA;
    wr(TCC_CTRLA_OFS, 8'h02);
    wr(TCC_CTRLB_OFS, 8'h58);
    wr(TCC_CMPA_HI_OFS, 8'h00);
    wr(TCC_CMPA_LO_OFS, ~expV[7:0]);
    #1 chk(topFromA, expV);
    run <= 1'b1;
    n = 0;
    while (topFromA !== {8'h00, ~expV[7:0]} && n < 700)
    begin
      @(posedge mclk);
      #1 n++;
    end
    if (n >= 700) begin n_errors++; results(); end
    chk(counter_value, 16'h0000);
    wr(TCC_CTRLA_OFS, 8'h01);
    wr(TCC_CTRLB_OFS, 8'h50);
    wr(TCC_CMPA_HI_OFS, 8'h00);
    wr(TCC_CMPA_LO_OFS, expV[7:0]);
    n = 0;
    while (topFromA !== {8'h00, expV[7:0]} && n < 700)
    begin
      @(posedge mclk);
      #1 n++;
    end
    if (n >= 700) begin n_errors++; results(); end
    chk(counter_value, 16'h0001);
    wr(TCC_MASK_OFS, 8'h00);
    results();
  end
endmodule
bind tcc_capture_compare tcc_capture_compare_assertions chk_i (
  .mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .capture_input_pin(capture_input_pin), .timerTick(timerTick), .capIrqAck(capIrqAck),
  .cmpAIrqAck(cmpAIrqAck), .capIrqReq(capIrqReq), .cmpAIrqReq(cmpAIrqReq),
  .cmpBIrqReq(cmpBIrqReq), .cmpAMatch(cmpAMatch), .waveform_mode_field(waveform_mode_field),
  .compareModeA(compareModeA), .topFromA(topFromA), .topIsCompareA(topIsCompareA)
);
`default_nettype wire
